/* File: hw/sps_cfg.svh */
// constants for the standby plant transfer sequencer: offsets, fields,
// reset values and timing
// assumes inclusion by bare name from any design file that needs them
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SPS_REG_CTRL      8'h00
`define SPS_REG_START_LIM 8'h04
`define SPS_REG_STOP_LIM  8'h08
`define SPS_REG_XFER_DLY  8'h0c
`define SPS_REG_THRESH    8'h10
`define SPS_REG_STATUS    8'h14
`define SPS_REG_EVENTS    8'h18
// ----------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------
`define SPS_CTRL_MODE_LO  0
`define SPS_CTRL_MODE_HI  1
`define SPS_CTRL_DUAL     2
`define SPS_CTRL_BRKFAIL  3
`define SPS_CTRL_EARLY    4
`define SPS_CTRL_RST      5'h04
`define SPS_START_LIM_RST 16'h0000
`define SPS_STOP_LIM_RST  16'h0000
`define SPS_XFER_DLY_RST  16'h0005
`define SPS_THR_CNT_RST   4'h1
`define SPS_THR_KW_RST    16'h0000
`define SPS_EARLY_ON      1'b1
// ----------------------------------------------------------------------
// timing: clock rate, controller tick, attempt window
// ----------------------------------------------------------------------
`define SPS_CLK_MHZ       125
`define SPS_TICK_US       1000
`define SPS_TICK_CYCLES   (`SPS_TICK_US * `SPS_CLK_MHZ)
`define SPS_ATT_TICKS     16'h0032
`define SPS_ATT_LAST      2'h2
`endif

/* File: hw/sps_pkg.sv */
// types for the standby plant transfer sequencer
// assumes sps_cfg.svh supplies the numeric constants
package sps_pkg;
  // one-hot sequence states
  typedef enum logic [11:0] {
    ST_IDLE   = 12'h001,
    ST_START  = 12'h002,
    ST_READY  = 12'h004,
    ST_GWAIT  = 12'h008,
    ST_MOPEN  = 12'h010,
    ST_XDLY   = 12'h020,
    ST_TCLOSE = 12'h040,
    ST_SUPPLY = 12'h080,
    ST_TOPEN  = 12'h100,
    ST_BDLY   = 12'h200,
    ST_MCLOSE = 12'h400,
    ST_STOP   = 12'h800
  } sps_state_e;
  // operating modes
  typedef enum logic [1:0] {
    MD_AUTO = 2'h0,
    MD_TEST = 2'h1,
    MD_EXT  = 2'h2,
    MD_RSVD = 2'h3
  } sps_mode_e;
endpackage : sps_pkg

/* File: hw/sps_tick.sv */
// controller time base: one-cycle tick every CYC clocks
// assumes a free-running clock and asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module sps_tick
  import sps_pkg::*;
#(
  parameter int unsigned CYC = 125000
)(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  output logic      o_tick
);
  logic [31:0] cnt;
  // divider; tick on wrap
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt    <= 32'h0;
      o_tick <= 1'b0;
    end
    else if (cnt == 32'(CYC - 1))
    begin
      cnt    <= 32'h0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt    <= cnt + 32'h1;
      o_tick <= 1'b0;
    end
  end
endmodule : sps_tick
`default_nettype wire

/* File: hw/sps_brk_op.sv */
// one breaker operation: open or close, three attempts, timed in ticks
// assumes i_fb is synchronised and i_go is a one-cycle pulse
`include "sps_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sps_brk_op
  import sps_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_tick,
  input  wire logic i_go,
  input  wire logic i_close,
  input  wire logic i_ilk_ok,
  input  wire logic i_fb,
  output logic      o_cmd_close,
  output logic      o_cmd_open,
  output logic      o_done,
  output logic      o_fail
);
  logic        busy;
  logic        dir;
  logic [1:0]  att;
  logic [15:0] tcnt;
  // attempt engine; a blocked close just burns its attempt
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      busy   <= 1'b0;
      dir    <= 1'b0;
      att    <= 2'h0;
      tcnt   <= 16'h0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      o_fail <= 1'b0;
      if (i_go)
      begin
        busy <= 1'b1;
        dir  <= i_close;
        att  <= 2'h0;
        tcnt <= 16'h0;
      end
      else if (busy && (i_fb == dir))
      begin
        busy   <= 1'b0;
        o_done <= 1'b1;
      end
      else if (busy && i_tick)
      begin
        if (tcnt == `SPS_ATT_TICKS)
        begin
          tcnt <= 16'h0;
          if (att == `SPS_ATT_LAST)
          begin
            busy   <= 1'b0;
            o_fail <= 1'b1;
          end
          else
          begin
            att <= att + 2'h1;
          end
        end
        else
        begin
          tcnt <= tcnt + 16'h1;
        end
      end
    end
  end
  // commands; the close is gated by the interlock every cycle
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_cmd_close <= 1'b0;
      o_cmd_open  <= 1'b0;
    end
    else
    begin
      o_cmd_close <= busy && dir && i_ilk_ok && !i_go;
      o_cmd_open  <= busy && !dir && !i_go;
    end
  end
endmodule : sps_brk_op
`default_nettype wire

/* File: hw/sps_seq.sv */
// standby plant transfer sequencer: run request, breaker sequencing,
// interlocks, sticky alarms and warnings, register port
// assumes peer and mains status inputs come from logic on I_CLK, and
// breaker feedback and voltage sense come from pins
//
// Functional notes
// - auto mode, no start inhibit: run on bad mains or option close fail
// - test and external run modes always run, ignoring start inhibit
// - never close one breaker while the other is closed
// - block a close when voltage sits on both sides of it
// - no load take-over during alarm, unload, stop or supply inhibit
// - tie breaker closes only after a unit breaker has closed
// - idle goes starting; ready peer or no peers proceeds; else keep starting
// - nonzero start limit exceeded raises start timeout warning
// - ready: hold on supply inhibit, stop on fault, else genset wait
// - genset wait advances on count and power match or none left
// - mains open, three tries; failure alarms and stops
// - transfer delay before tie close; stop or inhibit recloses mains
// - tie close, three tries; failure alarms and recloses mains
// - supplying: fault, deactivation or withdrawal opens the tie
// - tie open, three tries; fail stops, else delay then mains close
// - dual variant mains close, three tries; fail stops, else ready
// - stopping drops peer start, waits stop, timeout warns, restarts
// - mains-only variant: closed tie goes straight to mains open
// - mains-only variant: supply inhibit opens peer unit breakers
// - mains-only variant: mains reclose, three tries, failure alarms
// - early disconnect opens mains as soon as mains goes bad while starting or ready
//
// Our own choices: the placing of the registers and the strobed register port.
`include "sps_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sps_seq
  import sps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SPS_TICK_CYCLES
)(
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  input  wire logic        I_MAINS_BAD,
  input  wire logic        I_MAINS_LIVE,
  input  wire logic        I_START_INH,
  input  wire logic        I_SUPPLY_INH,
  input  wire logic        I_ALARM,
  input  wire logic        I_UNLOAD,
  input  wire logic        I_STOP_REQ,
  input  wire logic        I_PEERS_EXIST,
  input  wire logic        I_PEER_READY,
  input  wire logic        I_PEERS_STOPPED,
  input  wire logic        I_OTHER_NEED,
  input  wire logic        I_MORE_CAN_CLOSE,
  input  wire logic [3:0]  I_UNIT_CNT,
  input  wire logic [15:0] I_UNIT_KW,
  input  wire logic        I_MAINS_BRK_FB,
  input  wire logic        I_TIE_BRK_FB,
  input  wire logic        I_MAINS_V_LINE,
  input  wire logic        I_MAINS_V_LOAD,
  input  wire logic        I_TIE_V_GEN,
  input  wire logic        I_TIE_V_LOAD,
  output logic             O_MAINS_CLOSE,
  output logic             O_MAINS_OPEN,
  output logic             O_TIE_CLOSE,
  output logic             O_TIE_OPEN,
  output logic             O_PEER_START,
  output logic             O_UNIT_OPEN,
  output var sps_state_e   O_STATE
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic       mains_c;
  logic       tie_c;
  // two stages; only the second stage feeds logic
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
    end
    else
    begin
      pin_s1 <= {I_MAINS_BRK_FB, I_TIE_BRK_FB, I_MAINS_V_LINE,
                 I_MAINS_V_LOAD, I_TIE_V_GEN, I_TIE_V_LOAD};
      pin_s2 <= pin_s1;
    end
  end
  assign mains_c = pin_s2[5];
  assign tie_c   = pin_s2[4];

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [4:0]  ctrl;
  logic [15:0] start_lim;
  logic [15:0] stop_lim;
  logic [15:0] xfer_dly;
  logic [3:0]  thr_cnt;
  logic [15:0] thr_kw;
  logic [6:0]  events;
  logic [6:0]  ev_set;
  logic        wr_ev;
  sps_mode_e   mode;
  logic        dual;
  assign mode  = sps_mode_e'(ctrl[`SPS_CTRL_MODE_HI:`SPS_CTRL_MODE_LO]);
  assign dual  = ctrl[`SPS_CTRL_DUAL];
  assign wr_ev = I_WR && (I_ADDR == `SPS_REG_EVENTS);
  // configuration writes
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      ctrl      <= `SPS_CTRL_RST;
      start_lim <= `SPS_START_LIM_RST;
      stop_lim  <= `SPS_STOP_LIM_RST;
      xfer_dly  <= `SPS_XFER_DLY_RST;
      thr_cnt   <= `SPS_THR_CNT_RST;
      thr_kw    <= `SPS_THR_KW_RST;
    end
    else if (I_WR)
    begin
      case (I_ADDR)
        `SPS_REG_CTRL:      ctrl      <= I_WDATA[4:0];
        `SPS_REG_START_LIM: start_lim <= I_WDATA[15:0];
        `SPS_REG_STOP_LIM:  stop_lim  <= I_WDATA[15:0];
        `SPS_REG_XFER_DLY:  xfer_dly  <= I_WDATA[15:0];
        `SPS_REG_THRESH:
        begin
          thr_cnt <= I_WDATA[3:0];
          thr_kw  <= I_WDATA[31:16];
        end
        default: ;
      endcase
    end
  end
  // sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      events <= 7'h00;
    else if (wr_ev)
      events <= (events & ~I_WDATA[6:0]) | ev_set;
    else
      events <= events | ev_set;
  end
  // read data one cycle after the strobe, zero when idle or unmapped
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_RDATA <= 32'h0;
    else if (!I_RD)
      O_RDATA <= 32'h0;
    else
    begin
      case (I_ADDR)
        `SPS_REG_CTRL:      O_RDATA <= {27'h0, ctrl};
        `SPS_REG_START_LIM: O_RDATA <= {16'h0, start_lim};
        `SPS_REG_STOP_LIM:  O_RDATA <= {16'h0, stop_lim};
        `SPS_REG_XFER_DLY:  O_RDATA <= {16'h0, xfer_dly};
        `SPS_REG_THRESH:    O_RDATA <= {thr_kw, 12'h0, thr_cnt};
        `SPS_REG_STATUS:    O_RDATA <= {18'h0, tie_c, mains_c, O_STATE};
        `SPS_REG_EVENTS:    O_RDATA <= {25'h0, events};
        default:            O_RDATA <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // run request and interlocks
  // ----------------------------------------------------------------------
  logic run;
  logic stop_need;
  logic load_block;
  logic mains_ilk;
  logic tie_ilk;
  logic units_ok;
  logic early_open;
  // close-failure memory is the sticky mains close alarms
  assign run = (mode != MD_AUTO) ||
    (!I_START_INH && (I_MAINS_BAD || (ctrl[`SPS_CTRL_BRKFAIL] &&
     I_MAINS_LIVE && (events[3] || events[4]))));
  assign stop_need  = I_ALARM || I_UNLOAD || I_STOP_REQ || !run;
  assign load_block = stop_need || I_SUPPLY_INH;
  assign mains_ilk  = !tie_c && !(pin_s2[3] && pin_s2[2]);
  assign tie_ilk    = !mains_c && !(pin_s2[1] && pin_s2[0]) &&
                      (I_UNIT_CNT != 4'h0) && !load_block;
  assign units_ok   = ((I_UNIT_CNT >= thr_cnt) && (I_UNIT_KW >= thr_kw)) ||
                      !I_MORE_CAN_CLOSE;
  assign early_open = (ctrl[`SPS_CTRL_EARLY] == `SPS_EARLY_ON) &&
                      I_MAINS_BAD && mains_c;

  // ----------------------------------------------------------------------
  // time base and breaker operations
  // ----------------------------------------------------------------------
  logic       tick;
  sps_state_e state;
  sps_state_e next_state;
  logic       entry;
  logic       m_go;
  logic       t_go;
  logic       m_done;
  logic       m_fail;
  logic       t_done;
  logic       t_fail;
  logic [15:0] ticks;
  sps_tick #(
    .CYC (TICK_CYCLES)
  ) u_tick (
    .i_clk  (I_CLK),
    .i_nrst (I_NRST),
    .o_tick (tick)
  );
  assign entry = (state != O_STATE);
  assign m_go  = entry && ((state == ST_MOPEN) || (state == ST_MCLOSE));
  assign t_go  = entry && ((state == ST_TCLOSE) || (state == ST_TOPEN));
  sps_brk_op u_mains (
    .i_clk       (I_CLK),
    .i_nrst      (I_NRST),
    .i_tick      (tick),
    .i_go        (m_go),
    .i_close     (state == ST_MCLOSE),
    .i_ilk_ok    (mains_ilk),
    .i_fb        (mains_c),
    .o_cmd_close (O_MAINS_CLOSE),
    .o_cmd_open  (O_MAINS_OPEN),
    .o_done      (m_done),
    .o_fail      (m_fail)
  );
  sps_brk_op u_tie (
    .i_clk       (I_CLK),
    .i_nrst      (I_NRST),
    .i_tick      (tick),
    .i_go        (t_go),
    .i_close     (state == ST_TCLOSE),
    .i_ilk_ok    (tie_ilk),
    .i_fb        (tie_c),
    .o_cmd_close (O_TIE_CLOSE),
    .o_cmd_open  (O_TIE_OPEN),
    .o_done      (t_done),
    .o_fail      (t_fail)
  );
  // ticks spent in the current state
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      ticks <= 16'h0;
    else if (next_state != state)
      ticks <= 16'h0;
    else if (tick && (ticks != 16'hffff))
      ticks <= ticks + 16'h1;
  end

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  logic stop_to;
  assign stop_to = (stop_lim != 16'h0) && (ticks > stop_lim);
  // next state; breaker results only count in their own states
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (run)
          next_state = ST_START;
      ST_START:
        if (stop_need)
          next_state = ST_STOP;
        else if (early_open)
          next_state = ST_MOPEN;
        else if (I_PEER_READY || !I_PEERS_EXIST)
          next_state = ST_READY;
      ST_READY:
        if (stop_need)
          next_state = ST_STOP;
        else if (I_SUPPLY_INH)
          next_state = ST_READY;
        else if (early_open || (!dual && tie_c))
          next_state = ST_MOPEN;
        else if (mains_c || !dual)
          next_state = ST_GWAIT;
      ST_GWAIT:
        if (stop_need)
          next_state = ST_STOP;
        else if (units_ok || (!dual && tie_c))
          next_state = ST_MOPEN;
      ST_MOPEN:
        if (m_fail)
          next_state = ST_STOP;
        else if (m_done)
          next_state = dual ? ST_XDLY : ST_SUPPLY;
      ST_XDLY:
        if (load_block)
          next_state = ST_MCLOSE;
        else if (ticks >= xfer_dly)
          next_state = ST_TCLOSE;
      ST_TCLOSE:
        if (t_fail)
          next_state = ST_MCLOSE;
        else if (t_done)
          next_state = ST_SUPPLY;
      ST_SUPPLY:
        if (I_ALARM || I_UNLOAD || I_STOP_REQ || !run ||
            (dual && I_SUPPLY_INH))
          next_state = dual ? ST_TOPEN : ST_MCLOSE;
      ST_TOPEN:
        if (t_fail)
          next_state = ST_STOP;
        else if (t_done)
          next_state = ST_BDLY;
      ST_BDLY:
        if (ticks >= xfer_dly)
          next_state = ST_MCLOSE;
      ST_MCLOSE:
        if (m_fail)
          next_state = ST_STOP;
        else if (m_done)
          next_state = ST_READY;
      ST_STOP:
        if (run && !(I_ALARM || I_UNLOAD || I_STOP_REQ))
          next_state = ST_START;
        else if (I_OTHER_NEED || I_PEERS_STOPPED || stop_to)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end
  // state; O_STATE trails by one cycle so entries can be seen
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state   <= ST_IDLE;
      O_STATE <= ST_IDLE;
    end
    else
    begin
      state   <= next_state;
      O_STATE <= state;
    end
  end
  // event sources: alarms [4:0], warnings [6:5]
  always_comb
  begin
    ev_set    = 7'h00;
    ev_set[0] = (state == ST_MOPEN) && m_fail;
    ev_set[1] = (state == ST_TCLOSE) && t_fail;
    ev_set[2] = (state == ST_TOPEN) && t_fail;
    ev_set[3] = (state == ST_MCLOSE) && m_fail && dual;
    ev_set[4] = (state == ST_MCLOSE) && m_fail && !dual;
    ev_set[5] = (state == ST_START) && (start_lim != 16'h0) &&
                (ticks > start_lim);
    ev_set[6] = (state == ST_STOP) && stop_to && !I_PEERS_STOPPED &&
                !I_OTHER_NEED;
  end
  // peer start request and unit breaker open commands
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_PEER_START <= 1'b0;
      O_UNIT_OPEN  <= 1'b0;
    end
    else
    begin
      O_PEER_START <= (next_state != ST_IDLE) &&
                      (next_state != ST_STOP);
      O_UNIT_OPEN  <= !dual && (state == ST_SUPPLY) && !mains_c &&
                      tie_c && I_SUPPLY_INH;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_mopen_fail;
    (state == ST_MOPEN) && m_fail;
  endsequence
  sequence s_stopped;
    (state == ST_STOP) ##0 events[0];
  endsequence
  tie_close_ilk_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_TIE_CLOSE |-> $past(!mains_c && I_UNIT_CNT != 4'h0))
    else $error("tie close without interlock");
  mains_close_ilk_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_MAINS_CLOSE |-> $past(!tie_c && !(pin_s2[3] && pin_s2[2])))
    else $error("mains close without interlock");
  no_both_close_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !(O_MAINS_CLOSE && O_TIE_CLOSE))
    else $error("both breakers commanded closed");
  forced_run_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (mode != MD_AUTO && state == ST_IDLE) |=> state == ST_START)
    else $error("forced mode did not start");
  mopen_fail_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    s_mopen_fail |=> s_stopped)
    else $error("mains open failure not handled");
  start_warn_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (state == ST_START && start_lim != 16'h0 && ticks > start_lim)
    |=> events[5])
    else $error("start timeout warning missing");
  stop_drop_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (state == ST_STOP && $stable(state)) |-> !O_PEER_START)
    else $error("peer start held while stopping");
  unit_open_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_UNIT_OPEN |-> $past(I_SUPPLY_INH && !dual && tie_c))
    else $error("unit open without inhibit");
  tie_fail_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (state == ST_TCLOSE && t_fail) |=> (state == ST_MCLOSE) ##1
    (O_STATE == ST_MCLOSE))
    else $error("tie close failure did not reclose mains");
endmodule : sps_seq
`default_nettype wire

/* File: tb/sps_plant.sv */
// breakers, bus voltages and gensets on the far side of the sequencer
// assumes breaker commands are registered levels on the bench clock
`timescale 1ns/100ps
`default_nettype none
module sps_plant
(
  input  wire logic i_clk,
  input  wire logic i_stuck,
  input  wire logic i_live,
  input  wire logic i_gen,
  input  wire logic i_m_cl,
  input  wire logic i_m_op,
  input  wire logic i_t_cl,
  input  wire logic i_t_op,
  output logic      o_m_fb,
  output logic      o_t_fb,
  output logic      o_m_vl,
  output logic      o_m_vd,
  output logic      o_t_vg,
  output logic      o_t_vd
);
  logic [2:0] age;
  // a breaker moves only after its command has been held a few cycles
  initial
  begin
    o_m_fb = 1'b1;
    o_t_fb = 1'b0;
    age = 3'h0;
  end
  always @(posedge i_clk)
  begin
    age <= (i_m_cl | i_m_op | i_t_cl | i_t_op) ? age + 3'h1 : 3'h0;
    if (!i_stuck && age == 3'h3)
    begin
      if (i_m_cl) o_m_fb <= 1'b1;
      if (i_m_op) o_m_fb <= 1'b0;
      if (i_t_cl) o_t_fb <= 1'b1;
      if (i_t_op) o_t_fb <= 1'b0;
    end
  end
  // the load bus is live through whichever breaker is closed
  assign o_m_vl = i_live;
  assign o_t_vg = i_gen;
  assign o_m_vd = (o_m_fb & i_live) | (o_t_fb & i_gen);
  assign o_t_vd = o_m_vd;
endmodule : sps_plant
`default_nettype wire

/* File: tb/sps_seq_tb.sv */
// self-checking bench for the transfer sequencer
// assumes a shortened tick so breaker attempt windows stay short
`include "sps_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sps_seq_tb;
  import sps_pkg::*;
  localparam int TK = 4;
  logic I_CLK, I_NRST, I_WR, I_RD, I_MAINS_BAD, I_MAINS_LIVE, I_START_INH;
  logic I_SUPPLY_INH, I_ALARM, I_UNLOAD, I_STOP_REQ, I_PEERS_EXIST;
  logic I_PEER_READY, I_PEERS_STOPPED, I_OTHER_NEED, I_MORE_CAN_CLOSE;
  logic I_MAINS_BRK_FB, I_TIE_BRK_FB, I_MAINS_V_LINE, I_MAINS_V_LOAD;
  logic I_TIE_V_GEN, I_TIE_V_LOAD, O_MAINS_CLOSE, O_MAINS_OPEN;
  logic O_TIE_CLOSE, O_TIE_OPEN, O_PEER_START, O_UNIT_OPEN, stuck, t_ext, t_fb;
  logic [7:0]  I_ADDR;
  logic [31:0] I_WDATA, O_RDATA, seed;
  logic [3:0]  I_UNIT_CNT;
  logic [15:0] I_UNIT_KW;
  sps_state_e  O_STATE;
  int          bad_count, n_checks, k;
  logic [31:0] mdl [5] = '{`SPS_CTRL_RST, 0, 0, `SPS_XFER_DLY_RST,
    {`SPS_THR_KW_RST, 12'h0, `SPS_THR_CNT_RST}};
  logic [31:0] msk [5] = '{32'h1f, 32'hffff, 32'hffff, 32'hffff, 32'hffff000f};
  // mains is taken as live whenever it is in tolerance
  assign I_MAINS_LIVE = ~I_MAINS_BAD;
  assign I_TIE_BRK_FB = t_fb | t_ext;
  sps_seq #(.TICK_CYCLES(TK)) i_sps_seq (.*);
  sps_plant i_sps_plant (.i_clk(I_CLK), .i_stuck(stuck), .i_live(I_MAINS_LIVE),
    .i_gen(I_UNIT_CNT != 4'h0), .i_m_cl(O_MAINS_CLOSE), .i_m_op(O_MAINS_OPEN),
    .i_t_cl(O_TIE_CLOSE), .i_t_op(O_TIE_OPEN), .o_m_fb(I_MAINS_BRK_FB),
    .o_t_fb(t_fb), .o_m_vl(I_MAINS_V_LINE), .o_m_vd(I_MAINS_V_LOAD),
    .o_t_vg(I_TIE_V_GEN), .o_t_vd(I_TIE_V_LOAD));
  initial
  begin
    I_CLK = 1'b0;
    forever #4 I_CLK = ~I_CLK;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // writes also update the register model; status and events are not kept
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    if (a < 8'h14) mdl[a[4:2]] = d & msk[a[4:2]];
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 chk(O_RDATA, e);
  endtask : rd
  // bounded wait for a state, then compare it
  task automatic wst(input sps_state_e s, input int n);
    int i;
    for (i = 0; i < n && O_STATE !== s; i++) @(posedge I_CLK);
    chk({20'h0, O_STATE}, {20'h0, s});
  endtask : wst
  // hang guard sized well past the longest breaker failure chain
  initial
  begin
    repeat (20000) @(posedge I_CLK);
    bad_count++;
    conclude;
  end
  initial
  begin
    seed = 32'h2268d9a8;
    {I_WR, I_RD, I_MAINS_BAD, I_START_INH, I_SUPPLY_INH, I_ALARM, I_UNLOAD,
     I_STOP_REQ, I_OTHER_NEED, I_MORE_CAN_CLOSE, stuck, t_ext} = '0;
    {I_PEERS_EXIST, I_PEER_READY, I_PEERS_STOPPED} = 3'h7;
    {I_ADDR, I_WDATA, I_UNIT_CNT, I_UNIT_KW} = '0;
    I_NRST = 1'b0;
    repeat (4) @(posedge I_CLK);
    I_NRST <= 1'b1;
    chk({20'h0, O_STATE}, {20'h0, ST_IDLE});
    for (k = 0; k < 5; k++) rd(8'(k * 4), mdl[k]);
    rd(8'h1c, 32'h0);
    // status: tie open, mains closed, idle once the pin syncs have flushed
    rd(8'h14, {18'h0, 2'b01, ST_IDLE});
    repeat (4)
    begin
      wr(8'h04, $random(seed));
      rd(8'h04, mdl[1]);
    end
    wr(8'h04, 32'h0);
    $display("test registers done");
    I_START_INH <= 1'b1;
    I_MAINS_BAD <= 1'b1;
    repeat (20) @(posedge I_CLK);
    chk({20'h0, O_STATE}, {20'h0, ST_IDLE});
    wr(8'h00, 32'h5);
    wst(ST_START, 20);
    wr(8'h00, 32'h4);
    I_START_INH <= 1'b0;
    I_UNIT_CNT <= 4'h1;
    I_UNIT_KW <= $random(seed);
    wst(ST_SUPPLY, 3000);
    chk({I_MAINS_BRK_FB, I_TIE_BRK_FB}, 2'b01);
    I_PEERS_STOPPED <= 1'b0;
    I_MAINS_BAD <= 1'b0;
    wst(ST_STOP, 3000);
    chk({I_MAINS_BRK_FB, I_TIE_BRK_FB, O_PEER_START}, 3'b100);
    I_PEERS_STOPPED <= 1'b1;
    wst(ST_IDLE, 50);
    $display("test dual transfer done");
    stuck <= 1'b1;
    I_MAINS_BAD <= 1'b1;
    wst(ST_STOP, 3000);
    I_MAINS_BAD <= 1'b0;
    stuck <= 1'b0;
    wst(ST_IDLE, 50);
    rd(8'h18, 32'h1);
    wr(8'h18, 32'h1);
    rd(8'h18, 32'h0);
    $display("test mains open failure done");
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h2);
    {I_PEER_READY, I_PEERS_STOPPED} <= 2'b00;
    I_MAINS_BAD <= 1'b1;
    wst(ST_START, 20);
    repeat (6 * TK) @(posedge I_CLK);
    rd(8'h18, 32'h20);
    I_ALARM <= 1'b1;
    wst(ST_STOP, 20);
    repeat (6 * TK) @(posedge I_CLK);
    rd(8'h18, 32'h60);
    {I_ALARM, I_MAINS_BAD, I_PEER_READY, I_PEERS_STOPPED} <= 4'h3;
    wst(ST_IDLE, 50);
    wr(8'h18, 32'h7f);
    $display("test timeouts done");
    // external run with start inhibit and early disconnect, then the tie
    // and the mains both stick open so both close failures show
    {I_PEER_READY, I_START_INH} <= 2'b01;
    wr(8'h00, 32'h16);
    wst(ST_START, 20);
    I_MAINS_BAD <= 1'b1;
    wst(ST_MOPEN, 20);
    I_PEER_READY <= 1'b1;
    wst(ST_XDLY, 300);
    stuck <= 1'b1;
    wst(ST_MCLOSE, 3000);
    wst(ST_STOP, 3000);
    rd(8'h18, 32'ha);
    {stuck, I_MAINS_BAD, I_START_INH} <= 3'h0;
    wr(8'h00, 32'h4);
    wst(ST_IDLE, 50);
    wr(8'h18, 32'h7f);
    $display("test forced early transfer done");
    wr(8'h00, 32'h0);
    {t_ext, I_MORE_CAN_CLOSE, I_MAINS_BAD} <= 3'h7;
    I_UNIT_CNT <= 4'h0;
    wst(ST_SUPPLY, 3000);
    I_SUPPLY_INH <= 1'b1;
    repeat (4) @(posedge I_CLK);
    chk(O_UNIT_OPEN, 1'b1);
    I_SUPPLY_INH <= 1'b0;
    I_MAINS_BAD <= 1'b0;
    wst(ST_STOP, 3000);
    rd(8'h18, 32'h10);
    $display("test mains-only variant done");
    // live mains plus a sticky close failure starts the plant by option;
    // clearing the failure withdraws the request again
    t_ext <= 1'b0;
    wr(8'h00, 32'h8);
    wst(ST_GWAIT, 50);
    wr(8'h18, 32'h10);
    wst(ST_IDLE, 50);
    $display("test breaker-fail start done");
    conclude;
  end
endmodule : sps_seq_tb
`default_nettype wire
